/* File: rtl/dtr_track_select.sv */
// Purpose: drum track read selection, store write enables and register recirculation
// Assumes: one mclk cycle is one digit time; head and selector pins are asynchronous
// Notes: phase inputs come from the control sequencer on mclk
// Operation
// - only the selected storage track head reaches the read amplifier, all others are dropped.
// - the six-bit track number is plain binary, zero is track 0 and all ones is track 63.
// - the one-word registers recirculate every digit, the entering bit chosen by the instruction.
// - with the extra stage a register loops 20 bits, without it 19 bits, shifting right each pass.
// - program writes reach only the eight-track group picked by the selector, plus the fast track.
// - the analog track 8, or tracks 8 to 15 when so set, is never written by this path.
// - storage write enables are true only in the digit times where a store phase is active.
// - the accumulator enable combines its phase with the reference flop and spans the digit.
// - the auxiliary and fast track enables are formed the same way as the accumulator one.
// - without the fast enable the fast track write driver is fed from its own read output.
// - with the fast enable the fast track recirculation is blocked and register data written.
// - the storage path transfer enable copies the fast enable; register data reach the storage writing path only while it is off.
// - the three low track number bits pick which of the eight group tracks gets write current.
// - a store without the fast phase whose upper track bits differ from the selector group, off the fast track, errors.
`timescale 1ns/1ps
module dtr_track_select
  import dtr_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  // drum heads and manual selector
  input wire logic [63:0] trackHeadIn,
  input wire logic fastTrackReadOut,
  input wire logic [2:0] groupSelect,
  // instruction phases
  input wire logic storeActive,
  input wire logic accPhase,
  input wire logic auxPhase,
  input wire logic fastPhase,
  input wire logic accLoad,
  input wire logic auxLoad,
  // drum side outputs
  output logic storageReadAmplifier,
  output logic accStoreWriteEnable,
  output logic auxStoreWriteEnable,
  output logic fastTrackWriteEnable,
  output logic storagePathTransferEnable,
  output logic fastTrackWriteDriver,
  output logic [7:0] trackWriteDriverEn,
  output logic trackWriteData,
  output logic recordError
);
  // synchronisers for pins
  logic [63:0] headS1_reg, headS2_reg;
  logic fastS1_reg, fastS2_reg;
  logic [2:0] groupS1_reg, groupS2_reg;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      headS1_reg <= '0;
      headS2_reg <= '0;
      fastS1_reg <= 1'b0;
      fastS2_reg <= 1'b0;
      groupS1_reg <= '0;
      groupS2_reg <= '0;
    end else begin
      headS1_reg <= trackHeadIn;
      headS2_reg <= headS1_reg;
      fastS1_reg <= fastTrackReadOut;
      fastS2_reg <= fastS1_reg;
      groupS1_reg <= groupSelect;
      groupS2_reg <= groupS1_reg;
    end
  end

  // software registers
  logic [3:0] ctrl_reg;
  logic [5:0] trackNum_reg;
  logic [19:0] acc_reg, aux_reg;
  logic recErr_reg, overrun_reg, refPhase_reg;
  logic [31:0] rdData_reg;
  wire wrCtrl = regWr && regAddr == DTR_OFS_CTRL;
  wire wrTrack = regWr && regAddr == DTR_OFS_TRACK;
  wire wrStatus = regWr && regAddr == DTR_OFS_STATUS;
  wire wrAcc = regWr && regAddr == DTR_OFS_ACC;
  wire wrAux = regWr && regAddr == DTR_OFS_AUX;
  wire rdFifo = regRd && regAddr == DTR_OFS_FIFO;
  wire accExtra = ctrl_reg[DTR_CTRL_ACC_EXTRA];
  wire auxExtra = ctrl_reg[DTR_CTRL_AUX_EXTRA];
  wire analogWide = ctrl_reg[DTR_CTRL_ANALOG_WIDE];
  wire captureOn = ctrl_reg[DTR_CTRL_CAPTURE];

  // read selection
  wire headSel = headS2_reg[trackNum_reg];

  // phase combining: true and mirror halves of the digit time ored together
  wire accPhaseStar = accPhase;
  wire auxPhaseStar = auxPhase;
  wire fastPhaseStar = fastPhase;
  wire accEnNext = storeActive && ((accPhase && refPhase_reg) ||
                   (accPhaseStar && !refPhase_reg));
  wire auxEnNext = storeActive && ((auxPhase && refPhase_reg) ||
                   (auxPhaseStar && !refPhase_reg));
  wire fastEnNext = storeActive && ((fastPhase && refPhase_reg) ||
                    (fastPhaseStar && !refPhase_reg));
  wire regBit = auxPhase ? aux_reg[0] : acc_reg[0];
  wire fastSrc = fastEnNext ? regBit : fastS2_reg;

  // general storage write selection
  wire groupMatch = trackNum_reg[5:3] == groupS2_reg;
  wire isFast = trackNum_reg == DTR_FAST_TRACK;
  wire isAnalog = analogWide ? (trackNum_reg[5:3] == DTR_ANALOG_GROUP)
                             : (trackNum_reg == DTR_ANALOG_TRACK);
  // a fast store owns the register bit, so the general tracks stay idle then
  wire genStore = (accEnNext || auxEnNext) && !fastEnNext;
  wire genWrite = genStore && groupMatch && !isAnalog;
  wire recErrSet = genStore && !groupMatch && !isFast;
  logic [7:0] drvNext;
  for (genvar t = 0; t < 8; t++) begin : gDrv
    assign drvNext[t] = genWrite && trackNum_reg[2:0] == 3'(t);
  end

  // recirculation inputs chosen by the instruction
  wire accIn = accLoad ? storageReadAmplifier : acc_reg[0];
  wire auxIn = auxLoad ? storageReadAmplifier : aux_reg[0];
  wire [19:0] accNext = accExtra ? {accIn, acc_reg[19:1]}
                                 : {accIn, accIn, acc_reg[18:1]};
  wire [19:0] auxNext = auxExtra ? {auxIn, aux_reg[19:1]}
                                 : {auxIn, auxIn, aux_reg[18:1]};

  // capture of read words into the fifo
  logic [19:0] cap_reg;
  logic [4:0] bitCnt_reg;
  wire fifoReady, fifoValid, fifoFull, fifoEmpty;
  wire [19:0] fifoData;
  wire [19:0] capWord = {storageReadAmplifier, cap_reg[19:1]};
  wire wordDone = captureOn && bitCnt_reg == DTR_LAST_BIT;
  wire capPush = wordDone && fifoReady;
  wire ovrSet = wordDone && !fifoReady;

  dtr_fifo #(.WIDTH(DTR_WORD_W), .DEPTH(DTR_FIFO_DEPTH)) uFifo (
    .mclk(mclk),
    .reset_n(reset_n),
    .inValid(wordDone),
    .inReady(fifoReady),
    .inData(capWord),
    .outValid(fifoValid),
    .outReady(rdFifo),
    .outData(fifoData),
    .isFull(fifoFull),
    .isEmpty(fifoEmpty)
  );

  wire [31:0] statusWord = {24'h0, storageReadAmplifier, groupS2_reg, fifoFull,
                            fifoEmpty, overrun_reg, recErr_reg};
  wire [31:0] rdMux =
    (regAddr == DTR_OFS_CTRL) ? {28'h0, ctrl_reg} :
    (regAddr == DTR_OFS_TRACK) ? {26'h0, trackNum_reg} :
    (regAddr == DTR_OFS_STATUS) ? statusWord :
    (regAddr == DTR_OFS_ACC) ? {12'h0, acc_reg} :
    (regAddr == DTR_OFS_AUX) ? {12'h0, aux_reg} :
    (regAddr == DTR_OFS_FIFO) ? {11'h0, fifoValid, fifoData} : 32'h0;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= DTR_CTRL_RESET;
      trackNum_reg <= '0;
      rdData_reg <= '0;
    end else begin
      if (wrCtrl) ctrl_reg <= regWrData[3:0];
      if (wrTrack) trackNum_reg <= regWrData[5:0];
      rdData_reg <= regRd ? rdMux : 32'h0;
    end
  end

  // sticky flags: a set in the clearing cycle wins
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      recErr_reg <= 1'b0;
      overrun_reg <= 1'b0;
    end else begin
      recErr_reg <= recErrSet || (recErr_reg &&
                    !(wrStatus && regWrData[DTR_ST_REC_ERR]));
      overrun_reg <= ovrSet || (overrun_reg && !(wrStatus && regWrData[DTR_ST_OVERRUN]));
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      acc_reg <= '0;
      aux_reg <= '0;
    end else begin
      acc_reg <= wrAcc ? regWrData[19:0] : accNext;
      aux_reg <= wrAux ? regWrData[19:0] : auxNext;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cap_reg <= '0;
      bitCnt_reg <= '0;
    end else begin
      cap_reg <= capWord;
      if (!captureOn || bitCnt_reg == DTR_LAST_BIT) bitCnt_reg <= '0;
      else bitCnt_reg <= bitCnt_reg + 5'h01;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      refPhase_reg <= 1'b0;
      storageReadAmplifier <= 1'b0;
      accStoreWriteEnable <= 1'b0;
      auxStoreWriteEnable <= 1'b0;
      fastTrackWriteEnable <= 1'b0;
      storagePathTransferEnable <= 1'b0;
      fastTrackWriteDriver <= 1'b0;
      trackWriteDriverEn <= '0;
      trackWriteData <= 1'b0;
    end else begin
      refPhase_reg <= !refPhase_reg;
      storageReadAmplifier <= headSel;
      accStoreWriteEnable <= accEnNext;
      auxStoreWriteEnable <= auxEnNext;
      fastTrackWriteEnable <= fastEnNext;
      storagePathTransferEnable <= fastEnNext;
      fastTrackWriteDriver <= fastSrc;
      trackWriteDriverEn <= drvNext;
      trackWriteData <= genWrite ? regBit : 1'b0;
    end
  end

  assign regRdData = rdData_reg;
  assign recordError = recErr_reg;

  // checks
  logic [4:0] accQuiet_reg;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) accQuiet_reg <= '0;
    else if (wrAcc || accLoad || !accExtra || wrCtrl) accQuiet_reg <= '0;
    else if (accQuiet_reg != 5'h1F) accQuiet_reg <= accQuiet_reg + 5'h01;
  end

  // cycles since the accumulator last ran undisturbed as a 19-bit loop, and the auxiliary as a 20-bit loop
  logic [4:0] acc19Quiet_reg;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) acc19Quiet_reg <= '0;
    else if (wrAcc || accLoad || accExtra || wrCtrl) acc19Quiet_reg <= '0;
    else if (acc19Quiet_reg != 5'h1F) acc19Quiet_reg <= acc19Quiet_reg + 5'h01;
  end
  logic [4:0] auxQuiet_reg;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) auxQuiet_reg <= '0;
    else if (wrAux || auxLoad || !auxExtra || wrCtrl) auxQuiet_reg <= '0;
    else if (auxQuiet_reg != 5'h1F) auxQuiet_reg <= auxQuiet_reg + 5'h01;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  AST_READ_ROUTE: assert property (
    $stable(trackNum_reg) |=> storageReadAmplifier == $past(headS2_reg[trackNum_reg]))
    else $error("read amplifier not fed from selected track");
  AST_TRACK_ZERO: assert property (
    trackNum_reg == 6'h00 |=> storageReadAmplifier == $past(headS2_reg[0]))
    else $error("track zero not selected by all-zero number");
  AST_RECIRC_20: assert property (
    accQuiet_reg >= 5'(DTR_RECIRC_CHECK) |-> acc_reg == $past(acc_reg, 20))
    else $error("20-bit loop did not return word");
  AST_LOAD_BIT: assert property (
    accLoad && !wrAcc |=> acc_reg[19] == $past(storageReadAmplifier))
    else $error("loaded bit did not enter accumulator");
  AST_ACC_EN: assert property (
    storeActive && accPhase |=> accStoreWriteEnable)
    else $error("accumulator enable missing in store phase");
  AST_NO_STORE: assert property (
    !storeActive |=> !accStoreWriteEnable && !auxStoreWriteEnable && !fastTrackWriteEnable)
    else $error("write enable without store");
  AST_PHASE_ONLY: assert property (
    !accPhase && !auxPhase |=> trackWriteDriverEn == 8'h00)
    else $error("track written outside store phase");
  AST_AUX_FAST_EN: assert property (
    storeActive && auxPhase && fastPhase |=> auxStoreWriteEnable && fastTrackWriteEnable)
    else $error("aux or fast enable missing");
  AST_FAST_RECIRC: assert property (
    !fastEnNext |=> fastTrackWriteDriver == $past(fastS2_reg))
    else $error("fast track not recirculated");
  AST_FAST_OVERRIDE: assert property (
    storeActive && fastPhase && !auxPhase |=> fastTrackWriteDriver == $past(acc_reg[0]))
    else $error("fast track not fed from register");
  AST_TRANSFER: assert property (
    $rose(fastTrackWriteEnable) |-> $rose(storagePathTransferEnable))
    else $error("transfer enable not following fast enable");
  AST_GROUP_ONLY: assert property (
    |trackWriteDriverEn |-> $past(trackNum_reg[5:3]) == $past(groupS2_reg))
    else $error("write outside selected group");
  AST_ONE_TRACK: assert property (
    |trackWriteDriverEn |-> trackWriteDriverEn == (8'h01 << $past(trackNum_reg[2:0])))
    else $error("wrong group track driven");
  AST_ANALOG: assert property (
    trackNum_reg == DTR_ANALOG_TRACK |=> trackWriteDriverEn == 8'h00)
    else $error("analog track written");
  AST_REC_ERR: assert property (
    recErrSet |=> recordError)
    else $error("record error not flagged");
  AST_REC_ERR_HOLD: assert property (
    recordError && !(wrStatus && regWrData[DTR_ST_REC_ERR]) |=> recordError)
    else $error("record error dropped without clear");
  AST_RECIRC_19: assert property (
    acc19Quiet_reg >= 5'(DTR_RECIRC_CHECK - 1) |-> acc_reg[18:0] == $past(acc_reg[18:0], 19))
    else $error("19-bit loop did not return word");
  AST_AUX_RECIRC_20: assert property (
    auxQuiet_reg >= 5'(DTR_RECIRC_CHECK) |-> aux_reg == $past(aux_reg, 20))
    else $error("auxiliary 20-bit loop did not return word");
  AST_AUX_LOAD_BIT: assert property (
    auxLoad && !wrAux |=> aux_reg[19] == $past(storageReadAmplifier))
    else $error("loaded bit did not enter auxiliary register");
  AST_ACC_OFF: assert property (
    !accPhase |=> !accStoreWriteEnable)
    else $error("accumulator enable outside its phase");
  AST_AUX_EN: assert property (
    storeActive && auxPhase |=> auxStoreWriteEnable)
    else $error("auxiliary enable missing in store phase");
  AST_FAST_EN: assert property (
    storeActive && fastPhase |=> fastTrackWriteEnable)
    else $error("fast enable missing in store phase");
  AST_AUX_OVERRIDE: assert property (
    storeActive && fastPhase && auxPhase |=> fastTrackWriteDriver == $past(aux_reg[0]))
    else $error("fast track not fed from auxiliary register");
  AST_TRANSFER_EQ: assert property (
    storagePathTransferEnable == fastTrackWriteEnable)
    else $error("transfer enable differs from fast enable");
  AST_NO_STORE_DRV: assert property (
    !storeActive |=> trackWriteDriverEn == 8'h00 && !trackWriteData)
    else $error("track write current without store");
  AST_ANALOG_WIDE: assert property (
    analogWide && trackNum_reg[5:3] == DTR_ANALOG_GROUP |=> trackWriteDriverEn == 8'h00)
    else $error("analog group written");

  COV_ACC_STORE: cover property (accStoreWriteEnable && |trackWriteDriverEn);
  COV_LOAD: cover property (accLoad && auxLoad);
  COV_FAST_STORE: cover property ($rose(fastTrackWriteEnable));
  COV_REC_ERR: cover property ($rose(recordError));
  COV_OVERRUN: cover property (ovrSet);
endmodule : dtr_track_select

/* File: include/dtr_pkg.sv */
// Purpose: shared constants for the drum track read/write select block
// Assumes: one mclk cycle is one drum digit time
// Notes: register offsets are byte addresses of aligned 32-bit words
package dtr_pkg;
  localparam int unsigned DTR_CLK_MHZ = 50;
  localparam int unsigned DTR_ADDR_W = 8;
  localparam int unsigned DTR_TRACKS = 64;
  localparam int unsigned DTR_TRACK_W = 6;
  localparam int unsigned DTR_GROUP_W = 3;
  localparam int unsigned DTR_GROUP_TRACKS = 8;
  localparam int unsigned DTR_WORD_W = 20;
  localparam int unsigned DTR_FIFO_DEPTH = 8;
  localparam logic [5:0] DTR_FAST_TRACK = 6'h3E;
  localparam logic [5:0] DTR_ANALOG_TRACK = 6'h08;
  localparam logic [2:0] DTR_ANALOG_GROUP = 3'h1;
  localparam logic [4:0] DTR_LAST_BIT = 5'h13;
  // register offsets
  localparam logic [7:0] DTR_OFS_CTRL = 8'h00;
  localparam logic [7:0] DTR_OFS_TRACK = 8'h04;
  localparam logic [7:0] DTR_OFS_STATUS = 8'h08;
  localparam logic [7:0] DTR_OFS_ACC = 8'h0C;
  localparam logic [7:0] DTR_OFS_AUX = 8'h10;
  localparam logic [7:0] DTR_OFS_FIFO = 8'h14;
  // control fields
  localparam int unsigned DTR_CTRL_ACC_EXTRA = 0;
  localparam int unsigned DTR_CTRL_AUX_EXTRA = 1;
  localparam int unsigned DTR_CTRL_ANALOG_WIDE = 2;
  localparam int unsigned DTR_CTRL_CAPTURE = 3;
  localparam int unsigned DTR_CTRL_W = 4;
  localparam logic [3:0] DTR_CTRL_RESET = 4'h3;
  // status fields
  localparam int unsigned DTR_ST_REC_ERR = 0;
  localparam int unsigned DTR_ST_OVERRUN = 1;
  localparam int unsigned DTR_ST_EMPTY = 2;
  localparam int unsigned DTR_ST_FULL = 3;
  localparam int unsigned DTR_ST_GROUP_LO = 4;
  localparam int unsigned DTR_ST_READ_AMP = 7;
  localparam int unsigned DTR_RECIRC_CHECK = 20;
endpackage : dtr_pkg

/* File: rtl/dtr_fifo.sv */
// Purpose: small flip-flop FIFO with valid/ready on both sides
// Assumes: single clock, push and pop may happen in one cycle
// Notes: full and empty come straight from the occupancy count
`timescale 1ns/1ps
module dtr_fifo #(
  parameter int unsigned WIDTH = 20,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  // state
  output logic isFull,
  output logic isEmpty
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr_reg;
  logic [PW-1:0] rdPtr_reg;
  logic [PW:0] count_reg;
  wire push = inValid && inReady;
  wire pop = outValid && outReady;

  assign isFull = (count_reg == (PW+1)'(DEPTH));
  assign isEmpty = (count_reg == '0);
  assign inReady = !isFull;
  assign outValid = !isEmpty;
  assign outData = mem[rdPtr_reg];

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) wrPtr_reg <= (wrPtr_reg == PW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
      if (pop) rdPtr_reg <= (rdPtr_reg == PW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
      count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  for (genvar i = 0; i < DEPTH; i++) begin : gEntry
    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) mem[i] <= '0;
      else if (push && wrPtr_reg == PW'(i)) mem[i] <= inData;
    end
  end
endmodule : dtr_fifo

/* File: tb/dtr_drum_model.sv */
// Purpose: drum head and track selector plug model
// Assumes: heads read continuously, values change just after mclk
// Notes: one chosen head carries a one, all others read zero
`timescale 1ns/1ps
module dtr_drum_model (
  // clock
  input wire logic mclk,
  // bench controls
  input wire logic [5:0] headSel,
  input wire logic fastBit,
  input wire logic [2:0] plugGroup,
  // head and plug pins
  output logic [63:0] trackHeadIn,
  output logic fastTrackReadOut,
  output logic [2:0] groupSelect
);
  always @(posedge mclk) begin
    trackHeadIn <= 64'h1 << headSel;
    fastTrackReadOut <= fastBit;
    groupSelect <= plugGroup;
  end
endmodule : dtr_drum_model

/* File: tb/test_drum_track_read_write_select.sv */
// Purpose: self-checking bench for the track select block
// Assumes: outputs registered one digit after the phase inputs
// Notes: pin inputs need up to four cycles to settle through the model register and syncs
`timescale 1ns/1ps
module test_drum_track_read_write_select import dtr_pkg::*; ();
  logic mclk, reset_n, regWr, regRd, fastTrackReadOut, storeActive, accPhase, auxPhase;
  logic fastPhase, accLoad, auxLoad, storageReadAmplifier, accStoreWriteEnable;
  logic auxStoreWriteEnable, fastTrackWriteEnable, storagePathTransferEnable;
  logic fastTrackWriteDriver, trackWriteData, recordError, fastBit;
  logic [7:0] regAddr, trackWriteDriverEn;
  logic [31:0] regWrData, regRdData, d, e;
  logic [63:0] trackHeadIn;
  logic [2:0] groupSelect, plugGroup;
  logic [5:0] headSel;
  int n_mismatch = 0;
  int samples_checked = 0;
  dtr_track_select u_dut (.mclk(mclk), .reset_n(reset_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .trackHeadIn(trackHeadIn), .fastTrackReadOut(fastTrackReadOut),
    .groupSelect(groupSelect), .storeActive(storeActive), .accPhase(accPhase),
    .auxPhase(auxPhase), .fastPhase(fastPhase), .accLoad(accLoad), .auxLoad(auxLoad),
    .storageReadAmplifier(storageReadAmplifier), .accStoreWriteEnable(accStoreWriteEnable),
    .auxStoreWriteEnable(auxStoreWriteEnable), .fastTrackWriteEnable(fastTrackWriteEnable),
    .storagePathTransferEnable(storagePathTransferEnable),
    .fastTrackWriteDriver(fastTrackWriteDriver), .trackWriteDriverEn(trackWriteDriverEn),
    .trackWriteData(trackWriteData), .recordError(recordError));
  dtr_drum_model u_drum (.mclk(mclk), .headSel(headSel), .fastBit(fastBit),
    .plugGroup(plugGroup), .trackHeadIn(trackHeadIn),
    .fastTrackReadOut(fastTrackReadOut), .groupSelect(groupSelect));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 v = regRdData;
  endtask : rd
  task automatic store(input logic s, input logic a, input logic b, input logic f);
    @(posedge mclk);
    storeActive <= s;
    accPhase <= a;
    auxPhase <= b;
    fastPhase <= f;
    @(posedge mclk);
    {storeActive, accPhase, auxPhase, fastPhase} <= 4'h0;
    #1;
  endtask : store
  task automatic setup(input logic [2:0] g, input logic [5:0] t);
    plugGroup <= g;
    wr(DTR_OFS_TRACK, {26'h0, t});
    repeat (5) @(posedge mclk);
    #1;
  endtask : setup
  task automatic t_reset();
    rd(DTR_OFS_CTRL, d);
    chk(d, 32'h3);
    @(posedge mclk);
    #1 chk(regRdData, 32'h0);
    rd(DTR_OFS_STATUS, d);
    chk(d & 32'h4, 32'h4);
    wr(8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C, d);
    chk(d, 32'h0);
    chk({accStoreWriteEnable, auxStoreWriteEnable, fastTrackWriteEnable}, 32'h0);
    $display("reset test done");
  endtask : t_reset
  task automatic t_read();
    for (int i = 0; i < 4; i++) begin
      headSel <= 6'(i * 21);
      setup(3'h0, 6'(i * 21));
      chk(storageReadAmplifier, 32'h1);
      rd(DTR_OFS_STATUS, d);
      chk(d[7], 32'h1);
      setup(3'h0, 6'(i * 21) ^ 6'h01);
      chk(storageReadAmplifier, 32'h0);
    end
    $display("read select test done");
  endtask : t_read
  task automatic t_store();
    wr(DTR_OFS_ACC, 32'hFFFFF);
    for (int k = 0; k < 8; k++) begin
      setup(3'h2, 6'(16 + k));
      store(1'b1, 1'b1, 1'b0, 1'b0);
      chk(trackWriteDriverEn, 32'h1 << k);
      chk({accStoreWriteEnable, auxStoreWriteEnable, trackWriteData}, 32'h5);
      store(1'b0, 1'b1, 1'b1, 1'b1);
      chk({accStoreWriteEnable, auxStoreWriteEnable, fastTrackWriteEnable}, 32'h0);
    end
    rd(DTR_OFS_STATUS, d);
    chk(d[6:4], 32'h2);
    wr(DTR_OFS_AUX, 32'h0);
    store(1'b1, 1'b0, 1'b1, 1'b0);
    chk({accStoreWriteEnable, auxStoreWriteEnable, trackWriteData}, 32'h2);
    @(posedge mclk);
    #1 chk(auxStoreWriteEnable, 32'h0);
    $display("store test done");
  endtask : t_store
  task automatic t_error();
    setup(3'h2, 6'd35);
    store(1'b1, 1'b1, 1'b0, 1'b0);
    chk(trackWriteDriverEn, 32'h0);
    rd(DTR_OFS_STATUS, d);
    chk({d[6:4], d[0]}, 32'h5);
    wr(DTR_OFS_STATUS, 32'h1);
    setup(3'h2, DTR_FAST_TRACK);
    store(1'b1, 1'b1, 1'b0, 1'b0);
    chk(recordError, 32'h0);
    setup(3'h1, 6'd8);
    store(1'b1, 1'b1, 1'b0, 1'b0);
    chk(trackWriteDriverEn, 32'h0);
    setup(3'h1, 6'd9);
    store(1'b1, 1'b1, 1'b0, 1'b0);
    chk(trackWriteDriverEn, 32'h2);
    wr(DTR_OFS_CTRL, 32'h7);
    store(1'b1, 1'b1, 1'b0, 1'b0);
    chk(trackWriteDriverEn, 32'h0);
    wr(DTR_OFS_CTRL, 32'h3);
    $display("error test done");
  endtask : t_error
  task automatic t_fast();
    fastBit <= 1'b1;
    wr(DTR_OFS_AUX, 32'h0);
    repeat (5) @(posedge mclk);
    #1 chk({fastTrackWriteDriver, fastTrackWriteEnable}, 32'h2);
    store(1'b1, 1'b0, 1'b1, 1'b1);
    chk({fastTrackWriteEnable, storagePathTransferEnable, fastTrackWriteDriver}, 32'h6);
    fastBit <= 1'b0;
    wr(DTR_OFS_ACC, 32'hFFFFF);
    store(1'b1, 1'b1, 1'b0, 1'b1);
    chk({fastTrackWriteEnable, storagePathTransferEnable, fastTrackWriteDriver}, 32'h7);
    $display("fast track test done");
  endtask : t_fast
  task automatic t_loop(input logic [31:0] ctrl, input logic [7:0] a, input int same,
                        input int diff);
    wr(DTR_OFS_CTRL, ctrl);
    wr(a, 32'h00011);
    repeat (25) @(posedge mclk);
    rd(a, d);
    repeat (same - 2) @(posedge mclk);
    rd(a, e);
    chk(e, d);
    rd(a, d);
    repeat (diff - 2) @(posedge mclk);
    rd(a, e);
    chk(e == d, 32'h0);
    $display("loop test done");
  endtask : t_loop
  task automatic t_fifo();
    headSel <= 6'd5;
    setup(3'h0, 6'd5);
    wr(DTR_OFS_CTRL, 32'hB);
    repeat (190) @(posedge mclk);
    wr(DTR_OFS_CTRL, 32'h3);
    rd(DTR_OFS_STATUS, d);
    chk(d[3:1], 32'h5);
    for (int i = 0; i < 8; i++) begin
      rd(DTR_OFS_FIFO, d);
      chk(d, 32'h1FFFFF);
      repeat (3) @(posedge mclk);
    end
    rd(DTR_OFS_FIFO, d);
    chk(d[20], 32'h0);
    rd(DTR_OFS_STATUS, d);
    chk(d[3:2], 32'h1);
    $display("fifo test done");
  endtask : t_fifo
  task automatic t_load();
    wr(DTR_OFS_ACC, 32'h0);
    wr(DTR_OFS_AUX, 32'h0);
    accLoad <= 1'b1;
    auxLoad <= 1'b1;
    @(posedge mclk);
    {accLoad, auxLoad} <= 2'h0;
    rd(DTR_OFS_ACC, d);
    chk(d, 32'h40000);
    rd(DTR_OFS_AUX, d);
    chk(d, 32'h10000);
    $display("load test done");
  endtask : t_load
  initial begin
    #400000;
    n_mismatch++;
    conclude();
  end
  initial begin
    {reset_n, regWr, regRd, storeActive, accPhase, auxPhase, fastPhase} = 7'h0;
    {accLoad, auxLoad, fastBit} = 3'h0;
    regAddr = 8'h00;
    regWrData = 32'h0;
    headSel = 6'h00;
    plugGroup = 3'h0;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    t_reset();
    t_read();
    t_store();
    t_error();
    t_fast();
    t_loop(32'h3, DTR_OFS_ACC, 20, 19);
    t_loop(32'h2, DTR_OFS_ACC, 19, 20);
    t_loop(32'h1, DTR_OFS_AUX, 19, 20);
    t_fifo();
    t_load();
    conclude();
  end
endmodule : test_drum_track_read_write_select
